// ---- rtl/ring_map.vh ----
// register map and ring layout constants for the offer/return engine
`ifndef RING_MAP_VH
`define RING_MAP_VH
// register byte offsets
`define A_CTRL 8'h00
`define A_QSIZE 8'h04
`define A_OBASE 8'h08
`define A_RBASE 8'h0C
`define A_NTHR 8'h10
`define A_STATUS 8'h14
`define A_HEAD 8'h18
`define A_RET_ID 8'h1C
`define A_RET_LEN 8'h20
`define A_RET_GO 8'h24
`define A_IDX 8'h28
// control register fields
`define C_EN 0
`define C_EVT 1
`define C_NONOTIFY 2
`define C_KICK 3
`define C_PUBLISH 4
// reset value and upper limit of the queue size
`define QSIZE_RST 16'h0100
`define QSIZE_MAX 16'h8000
// ring layout: header word, entry sizes
`define RING_HDR 32'h0000_0004
`define OFFER_ENT 32'h0000_0002
`define RET_ENT 32'h0000_0008
`define RET_LEN_OFS 32'h0000_0004
`define NO_SUPPRESS 16'h0001
// axi responses
`define RESP_OK 2'h0
`define RESP_DECERR 2'h3
`endif

// ---- rtl/doorbell_sync.v ----
// three-stage synchroniser for the asynchronous doorbell pin
module doorbell_sync (
  input wire aclk,
  input wire aresetn,
  input wire pin,
  output reg level_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // level only moves once stages two and three agree
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_r <= s3_r;
    end
  end
endmodule // doorbell_sync

// ---- rtl/suppress_decide.v ----
// decides whether a newly published return entry interrupts the guest
module suppress_decide (
  input wire evt_en,
  input wire [15:0] offer_flags,
  input wire [15:0] threshold,
  input wire [15:0] placed_idx,
  output wire fire
);
  // threshold mode ignores the flag bit; flag mode ignores threshold
  assign fire = evt_en ? (placed_idx == threshold)
                       : ~offer_flags[0];
endmodule // suppress_decide

// ---- rtl/split_ring_offer_return_engine.v ----
// device end of a split offer/return ring pair with axi4-lite control
`include "ring_map.vh"
module split_ring_offer_return_engine (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire doorbell_pin,
  output reg mem_req,
  output reg mem_we,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  output reg [3:0] mem_be,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  output reg guest_irq
);
  localparam S_IDLE = 11'h001;
  localparam S_ROIDX = 11'h002;
  localparam S_RHEAD = 11'h004;
  localparam S_WID = 11'h008;
  localparam S_WLEN = 11'h010;
  localparam S_WUIDX = 11'h020;
  localparam S_ROFLG = 11'h040;
  localparam S_ROTHR = 11'h080;
  localparam S_FIRE = 11'h100;
  localparam S_WRFLG = 11'h200;
  localparam S_WRTHR = 11'h400;

  reg [10:0] state_r;
  reg enable_r;
  reg evt_en_r;
  reg no_notify_r;
  reg [15:0] qsize_r;
  reg [31:0] obase_r;
  reg [31:0] rbase_r;
  reg [15:0] nthr_r;
  reg [31:0] ret_id_r;
  reg [31:0] ret_len_r;
  reg ret_pend_r;
  reg poll_pend_r;
  reg sup_pend_r;
  reg [15:0] head_r;
  reg head_valid_r;
  reg [15:0] last_offer_r;
  reg [15:0] avail_seen_r;
  reg [15:0] used_idx_r;
  reg [15:0] placed_r;
  reg [15:0] oflags_r;
  reg [15:0] othr_r;
  reg lane_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg aw_have_r;
  reg w_have_r;
  reg db_prev_r;
  wire db_level;
  wire fire;
  wire [15:0] rd_half;
  wire do_wr;
  wire db_evt;
  reg [31:0] ea;
  reg [31:0] ed;
  reg [3:0] eb;
  reg ew;
  reg [31:0] rd_val;
  reg rd_ok;
  reg wr_ok;

  // byte-lane merge for register writes under wstrb
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // byte-lane merge into a 16-bit register; upper lanes are dropped
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] nw;
    input [3:0] strb;
    reg [31:0] full;
    begin
      full = merge({16'h0, old}, nw, strb);
      merge16 = full[15:0];
    end
  endfunction

  // ring slot: indices are 16-bit and wrap, size is a power of two
  function [31:0] slot;
    input [15:0] idx;
    input [15:0] qs;
    begin
      slot = {16'h0, idx & (qs - 16'h1)};
    end
  endfunction

  // pick the halfword of a fetched word at byte offset 0 or 2
  function [15:0] half;
    input [31:0] w;
    input hi;
    begin
      half = hi ? w[31:16] : w[15:0];
    end
  endfunction

  doorbell_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(doorbell_pin),
    .level_r(db_level)
  );

  suppress_decide u_decide (
    .evt_en(evt_en_r),
    .offer_flags(oflags_r),
    .threshold(othr_r),
    .placed_idx(placed_r),
    .fire(fire)
  );

  assign db_evt = db_level & ~db_prev_r;
  assign rd_half = half(mem_rdata, lane_r);
  assign do_wr = aw_have_r & w_have_r & ~bvalid;

  // shared-memory access for the current state
  always @*
  begin
    ea = obase_r;
    ed = 32'h0000_0000;
    eb = 4'hF;
    ew = 1'b0;
    case (state_r)
      S_ROIDX: ea = obase_r;
      // head of one chain, one halfword per slot
      S_RHEAD: ea = obase_r + `RING_HDR
                  + `OFFER_ENT * slot(last_offer_r, qsize_r);
      S_WID:
      begin
        ea = rbase_r + `RING_HDR
           + `RET_ENT * slot(used_idx_r, qsize_r);
        ed = ret_id_r;
        ew = 1'b1;
      end
      S_WLEN:
      begin
        ea = rbase_r + `RING_HDR + `RET_LEN_OFS
           + `RET_ENT * slot(used_idx_r, qsize_r);
        ed = ret_len_r;
        ew = 1'b1;
      end
      S_WUIDX:
      begin
        ea = rbase_r;
        ed = {used_idx_r + 16'h1, 16'h0000};
        eb = 4'hC;
        ew = 1'b1;
      end
      S_ROFLG: ea = obase_r;
      // trailing threshold sits after the last offer slot
      S_ROTHR: ea = obase_r + `RING_HDR
                  + `OFFER_ENT * {16'h0, qsize_r};
      S_WRFLG:
      begin
        ea = rbase_r;
        ed = {16'h0000, evt_en_r ? 16'h0000
              : {15'h0, no_notify_r}};
        eb = 4'h3;
        ew = 1'b1;
      end
      S_WRTHR:
      begin
        ea = rbase_r + `RING_HDR + `RET_ENT * {16'h0, qsize_r};
        ed = {16'h0000, nthr_r};
        eb = 4'h3;
        ew = 1'b1;
      end
      default: ea = obase_r;
    endcase
  end

  // register read mux and address decode
  always @*
  begin
    rd_ok = 1'b1;
    case (araddr)
      `A_CTRL: rd_val = {29'h0, no_notify_r, evt_en_r, enable_r};
      `A_QSIZE: rd_val = {16'h0, qsize_r};
      `A_OBASE: rd_val = obase_r;
      `A_RBASE: rd_val = rbase_r;
      `A_NTHR: rd_val = {16'h0, nthr_r};
      `A_STATUS: rd_val = {avail_seen_r, 11'h0, poll_pend_r, sup_pend_r,
                           ret_pend_r, head_valid_r, ~state_r[0]};
      `A_HEAD: rd_val = {16'h0, head_r};
      `A_RET_ID: rd_val = ret_id_r;
      `A_RET_LEN: rd_val = ret_len_r;
      `A_IDX: rd_val = {last_offer_r, used_idx_r};
      default:
      begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
    case (aw_addr_r)
      `A_CTRL, `A_QSIZE, `A_OBASE, `A_RBASE, `A_NTHR, `A_RET_ID,
      `A_RET_LEN, `A_RET_GO: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // engine, memory master and axi slave; later writes win, so the
  // register side effects sit last and a set beats a same-cycle clear
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= S_IDLE;
      enable_r <= 1'b0;
      evt_en_r <= 1'b0;
      no_notify_r <= 1'b0;
      qsize_r <= `QSIZE_RST;
      obase_r <= 32'h0000_0000;
      rbase_r <= 32'h0000_0000;
      nthr_r <= 16'h0000;
      ret_id_r <= 32'h0000_0000;
      ret_len_r <= 32'h0000_0000;
      ret_pend_r <= 1'b0;
      poll_pend_r <= 1'b0;
      sup_pend_r <= 1'b0;
      head_r <= 16'h0000;
      head_valid_r <= 1'b0;
      last_offer_r <= 16'h0000;
      avail_seen_r <= 16'h0000;
      used_idx_r <= 16'h0000;
      placed_r <= 16'h0000;
      oflags_r <= 16'h0000;
      othr_r <= 16'h0000;
      lane_r <= 1'b0;
      db_prev_r <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      mem_be <= 4'h0;
      guest_irq <= 1'b0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OK;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OK;
    end
    else
    begin
      db_prev_r <= db_level;
      guest_irq <= 1'b0;
      // idle dispatch: returns first, then suppression, then polling
      if (state_r == S_IDLE)
      begin
        if (enable_r && ret_pend_r)
          state_r <= S_WID;
        else if (enable_r && sup_pend_r)
        begin
          sup_pend_r <= 1'b0;
          state_r <= S_WRFLG;
        end
        else if (enable_r && poll_pend_r && !head_valid_r)
        begin
          poll_pend_r <= 1'b0;
          state_r <= S_ROIDX;
        end
      end
      else if (state_r == S_FIRE)
      begin
        guest_irq <= fire;
        ret_pend_r <= 1'b0;
        state_r <= S_IDLE;
      end
      else if (!mem_req)
      begin
        // one access per state; request holds until acknowledged
        mem_req <= 1'b1;
        mem_we <= ew;
        mem_addr <= {ea[31:2], 2'b00};
        mem_wdata <= ew ? (ea[1] ? {ed[15:0], 16'h0} : ed) : 32'h0;
        mem_be <= ea[1] ? 4'hC : eb;
        lane_r <= ea[1];
      end
      else if (mem_ack)
      begin
        mem_req <= 1'b0;
        case (state_r)
          S_ROIDX:
          begin
            avail_seen_r <= mem_rdata[31:16];
            // equal index means a needless doorbell: nothing to do
            if (mem_rdata[31:16] != last_offer_r)
              state_r <= S_RHEAD;
            else
              state_r <= S_IDLE;
          end
          S_RHEAD:
          begin
            head_r <= rd_half;
            head_valid_r <= 1'b1;
            last_offer_r <= last_offer_r + 16'h1;
            state_r <= S_IDLE;
          end
          S_WID: state_r <= S_WLEN;
          // count lands before the index that publishes it
          S_WLEN: state_r <= S_WUIDX;
          S_WUIDX:
          begin
            placed_r <= used_idx_r;
            used_idx_r <= used_idx_r + 16'h1;
            state_r <= S_ROFLG;
          end
          S_ROFLG:
          begin
            oflags_r <= mem_rdata[15:0];
            state_r <= evt_en_r ? S_ROTHR : S_FIRE;
          end
          S_ROTHR:
          begin
            othr_r <= rd_half;
            state_r <= S_FIRE;
          end
          S_WRFLG: state_r <= evt_en_r ? S_WRTHR : S_IDLE;
          S_WRTHR: state_r <= S_IDLE;
          default: state_r <= S_IDLE;
        endcase
      end
      // axi write channels taken in either order, one write in flight
      if (awvalid && awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_have_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        wready <= 1'b0;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      // read channel; reading the head register hands the head over
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_val;
        rresp <= rd_ok ? `RESP_OK : `RESP_DECERR;
        if (araddr == `A_HEAD && head_valid_r)
        begin
          head_valid_r <= 1'b0;
          if (avail_seen_r != last_offer_r)
            poll_pend_r <= 1'b1;
        end
      end
      if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
      // doorbells are advisory; a spare one costs one index fetch
      if (db_evt && enable_r)
        poll_pend_r <= 1'b1;
      if (do_wr)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? `RESP_OK : `RESP_DECERR;
        case (aw_addr_r)
          `A_CTRL:
          begin
            if (w_strb_r[0])
            begin
              enable_r <= w_data_r[`C_EN];
              evt_en_r <= w_data_r[`C_EVT];
              no_notify_r <= w_data_r[`C_NONOTIFY];
              if (w_data_r[`C_KICK])
                poll_pend_r <= 1'b1;
              if (w_data_r[`C_PUBLISH])
                sup_pend_r <= 1'b1;
            end
          end
          `A_QSIZE:
          begin
            // larger sizes would alias full and empty rings
            if (merge({16'h0, qsize_r}, w_data_r, w_strb_r) > 
                {16'h0, `QSIZE_MAX})
              qsize_r <= `QSIZE_MAX;
            else
              qsize_r <= merge16(qsize_r, w_data_r, w_strb_r);
          end
          `A_OBASE: obase_r <= merge(obase_r, w_data_r, w_strb_r);
          `A_RBASE: rbase_r <= merge(rbase_r, w_data_r, w_strb_r);
          `A_NTHR: nthr_r <= merge16(nthr_r, w_data_r, w_strb_r);
          // id and count stay frozen while a return is in flight
          `A_RET_ID:
            if (!ret_pend_r)
              ret_id_r <= merge(ret_id_r, w_data_r, w_strb_r);
          `A_RET_LEN:
            if (!ret_pend_r)
              ret_len_r <= merge(ret_len_r, w_data_r, w_strb_r);
          // software has written the data already
          `A_RET_GO:
            if (w_strb_r[0] && w_data_r[0])
              ret_pend_r <= 1'b1;
          default: bresp <= `RESP_DECERR;
        endcase
      end
    end
  end
endmodule // split_ring_offer_return_engine

// ---- sim/ring_engine_props.sv ----
// concurrent checks on the ring engine bus, memory and interrupt ports
`include "ring_map.vh"
module ring_engine_props (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire rvalid,
  input wire rready,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [3:0] mem_be,
  input wire mem_ack,
  input wire guest_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic full_r;
  // remembers whether the last acknowledged memory write was a full word
  always @(posedge aclk)
  begin
    if (!aresetn)
      full_r <= 1'b0;
    else if (mem_req && mem_ack && mem_we)
      full_r <= (mem_be == 4'hF);
  end
  chk_b_holds: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped before taken");
  chk_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before taken");
  // both halves are registered first, so the response shows two cycles after the handshake
  chk_b_follows: assert property (awvalid && awready && wvalid && wready
    |-> ##2 bvalid) else $error("write response late");
  chk_r_follows: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  chk_ready_low: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  chk_bresp_legal: assert property (bvalid |->
    bresp == `RESP_OK || bresp == `RESP_DECERR)
    else $error("illegal write response code");
  chk_mem_holds: assert property (mem_req && !mem_ack |=> mem_req
    && $stable(mem_addr) && $stable(mem_we) && $stable(mem_be))
    else $error("memory request changed before ack");
  chk_mem_drop: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request held after ack");
  chk_addr_align: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("memory address not word aligned");
  chk_len_first: assert property (mem_req && mem_we && mem_be == 4'hC
    |-> full_r)
    else $error("index published before entry words");
  chk_irq_pulse: assert property (guest_irq |=> !guest_irq)
    else $error("interrupt longer than one cycle");
endmodule // ring_engine_props

// ---- sim/guest_mem.sv ----
// shared guest memory answering the engine's memory port
module guest_mem (
  input wire aclk,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire [3:0] mem_be,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] m [0:255];
  integer lat = 0;
  integer cnt = 0;
  integer k;
  // rings start cleared, offer flags zero means notify
  initial
  begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    for (k = 0; k < 256; k = k + 1)
      m[k] = 32'h0;
  end
  // ack after lat wait cycles; idle read data toggles so stale reads show
  always @(posedge aclk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack)
    begin
      if (cnt >= lat)
      begin
        cnt <= 0;
        mem_ack <= 1'b1;
        if (mem_we)
        begin
          for (k = 0; k < 4; k = k + 1)
            if (mem_be[k])
              m[mem_addr[9:2]][8*k+:8] <= mem_wdata[8*k+:8];
        end
        else
          mem_rdata <= m[mem_addr[9:2]];
      end
      else
        cnt <= cnt + 1;
    end
  end
endmodule // guest_mem

// ---- sim/split_ring_offer_return_engine_tb.sv ----
// register-level tests of the offer/return ring engine
`include "ring_map.vh"
module split_ring_offer_return_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, doorbell_pin = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d;
  logic [3:0] wstrb = 0;
  wire awready, wready, bvalid, arready, rvalid, mem_req, mem_we;
  wire mem_ack, guest_irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, mem_addr, mem_wdata, mem_rdata;
  wire [3:0] mem_be;
  integer errors = 0, checked = 0, irqs = 0, cyc = 0, ridx = 0;
  split_ring_offer_return_engine u_split_ring_offer_return_engine (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .doorbell_pin(doorbell_pin), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .guest_irq(guest_irq));
  guest_mem u_guest_mem (.aclk(aclk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial forever #5 aclk = ~aclk;
  // count interrupt pulses seen by the guest
  always @(posedge aclk)
    if (guest_irq === 1'b1)
      irqs <= irqs + 1;
  // hang guard, well above the length of the sequence
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      errors = errors + 1;
      results;
    end
  end
  task results;
    begin
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task wr(input [7:0] a, input [31:0] v, input [1:0] er);
    logic ta, tw;
    begin
      ta = 0;
      tw = 0;
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ta && tw))
      begin
        @(posedge aclk);
        if (awready && !ta)
        begin
          ta = 1;
          awvalid <= 1'b0;
        end
        if (wready && !tw)
        begin
          tw = 1;
          wvalid <= 1'b0;
        end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      cmp({30'h0, bresp}, {30'h0, er});
    end
  endtask
  task rd(input [7:0] a, input [1:0] er);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      cmp({30'h0, rresp}, {30'h0, er});
    end
  endtask
  // let the doorbell sync settle, then poll status until all work is done, at most 40 reads
  task idle;
    integer n;
    logic [31:0] s;
    begin
      repeat (8) @(posedge aclk);
      n = 0;
      s = 32'h1;
      while (s[4:0] !== 5'h0 && n < 40)
      begin
        rd(`A_STATUS, `RESP_OK);
        s = d;
        n = n + 1;
      end
      repeat (4) @(posedge aclk);
    end
  endtask
  // hand back one chain and check entry, index and interrupt count
  task ret(input [31:0] id, input [31:0] len, input integer ie);
    integer i0;
    logic [7:0] w;
    begin
      i0 = irqs;
      w = 8'h81 + 2 * (ridx % 4);
      wr(`A_RET_ID, id, `RESP_OK);
      wr(`A_RET_LEN, len, `RESP_OK);
      wr(`A_RET_GO, 32'h1, `RESP_OK);
      idle;
      ridx = ridx + 1;
      cmp(u_guest_mem.m[w], id);
      cmp(u_guest_mem.m[w+1], len);
      cmp(u_guest_mem.m[8'h80] >> 16, ridx);
      cmp(irqs - i0, ie);
    end
  endtask
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    bready <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    rd(`A_QSIZE, `RESP_OK);
    cmp(d, 32'h100);
    rd(`A_IDX, `RESP_OK);
    cmp(d, 32'h0);
    rd(8'h30, `RESP_DECERR);
    cmp(d, 32'h0);
    wr(8'h30, 32'h1, `RESP_DECERR);
    wr(`A_QSIZE, 32'h0001_0000, `RESP_OK);
    rd(`A_QSIZE, `RESP_OK);
    cmp(d, 32'h8000);
    wr(`A_QSIZE, 32'h4, `RESP_OK);
    wr(`A_OBASE, 32'h100, `RESP_OK);
    wr(`A_RBASE, 32'h200, `RESP_OK);
    wr(`A_CTRL, 32'h1, `RESP_OK);
    // flag mode: flags zero interrupts, flags one stays quiet
    ret(32'h5, 32'h40, 1);
    u_guest_mem.m[8'h40] = 32'h1;
    ret(32'h6, 32'h0, 0);
    // threshold mode with a slow memory; the flag bit must be ignored
    wr(`A_CTRL, 32'h3, `RESP_OK);
    u_guest_mem.m[8'h43] = 32'h2;
    u_guest_mem.lat = 3;
    ret(32'h7, 32'h8, 1);
    ret(32'h8, 32'h8, 0);
    ret(32'h9, 32'h8, 0);
    // doorbell poll picks up one new head
    u_guest_mem.m[8'h40] = 32'h0001_0000;
    u_guest_mem.m[8'h41] = 32'h7;
    doorbell_pin <= 1'b1;
    idle;
    rd(`A_STATUS, `RESP_OK);
    cmp(d & 32'h2, 32'h2);
    rd(`A_HEAD, `RESP_OK);
    cmp(d, 32'h7);
    rd(`A_IDX, `RESP_OK);
    cmp(d, 32'h0001_0005);
    // a needless doorbell with nothing new offered
    doorbell_pin <= 1'b0;
    idle;
    doorbell_pin <= 1'b1;
    idle;
    rd(`A_STATUS, `RESP_OK);
    cmp(d & 32'h2, 32'h0);
    // kicked poll reads the second slot's high halfword
    u_guest_mem.m[8'h41] = 32'h0009_0007;
    u_guest_mem.m[8'h40] = 32'h0002_0000;
    wr(`A_CTRL, 32'hB, `RESP_OK);
    idle;
    rd(`A_HEAD, `RESP_OK);
    cmp(d, 32'h9);
    // publish return flags, then the notify threshold
    wr(`A_CTRL, 32'h15, `RESP_OK);
    idle;
    cmp(u_guest_mem.m[8'h80], 32'h0005_0001);
    wr(`A_NTHR, 32'h9, `RESP_OK);
    wr(`A_CTRL, 32'h13, `RESP_OK);
    idle;
    cmp(u_guest_mem.m[8'h80], 32'h0005_0000);
    cmp(u_guest_mem.m[8'h89] & 32'hFFFF, 32'h9);
    results;
  end
endmodule // split_ring_offer_return_engine_tb
bind split_ring_offer_return_engine ring_engine_props u_ring_engine_props (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_be(mem_be), .mem_ack(mem_ack),
  .guest_irq(guest_irq));
